// File: swp_defs.vh
`ifndef SWP_DEFS_VH
`define SWP_DEFS_VH

// byte register addresses
`define SWP_ADDR_CTRL_HI 8'h80
`define SWP_ADDR_CTRL_LO 8'h81
`define SWP_ADDR_PTS_HI 8'h88
`define SWP_ADDR_PTS_LO 8'h89
`define SWP_ADDR_SETTLE_HI 8'h8a
`define SWP_ADDR_SETTLE_LO 8'h8b
`define SWP_ADDR_STATUS 8'h8f
`define SWP_ADDR_TEMP_HI 8'h92
`define SWP_ADDR_TEMP_LO 8'h93
`define SWP_ADDR_REAL_HI 8'h94
`define SWP_ADDR_REAL_LO 8'h95
`define SWP_ADDR_IMAG_HI 8'h96
`define SWP_ADDR_IMAG_LO 8'h97

// control word
`define SWP_CTRL_RESET_VAL 16'ha000
`define SWP_CMD_INIT 4'h1
`define SWP_CMD_START 4'h2
`define SWP_CMD_INC 4'h3
`define SWP_CMD_REPEAT 4'h4
`define SWP_CMD_TEMP 4'h9
`define SWP_CTRL_RST_BIT 4

// settling multiplier codes
`define SWP_MULT_X1 2'b00
`define SWP_MULT_X2 2'b01
`define SWP_MULT_RSVD 2'b10
`define SWP_MULT_X4 2'b11

// status bit positions
`define SWP_STAT_TEMP_BIT 0
`define SWP_STAT_POINT_BIT 1
`define SWP_STAT_SWEEP_BIT 2

// serial bus
`define SWP_I2C_ADDR 7'h0d
`define SWP_I2C_PTR_CMD 8'hb0

// converter samples per point
`define SWP_SAMPLES 1024

`endif

// File: swp_settle_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "swp_defs.vh"

module swp_settle_timer (
  input wire core_clk_i, // system clock
  input wire rst_n_i, // sync reset, active low
  input wire load_i, // start a settling wait
  input wire abort_i, // drop a running wait
  input wire [8:0] base_i, // base cycle count
  input wire [1:0] mult_i, // multiplier code
  input wire tick_i, // one pulse per excitation cycle
  output reg done_o // one-cycle pulse when the wait ends
);

  reg run_q;
  reg [10:0] cnt_q;
  reg [10:0] total;

  always @* begin
    case (mult_i)
      `SWP_MULT_X2: total = {1'b0, base_i, 1'b0}; // RL7
      `SWP_MULT_X4: total = {base_i, 2'b00}; // RL8
      default: total = {2'b00, base_i}; // RL22
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
      cnt_q <= 11'h000;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        run_q <= 1'b1;
        cnt_q <= total;
      end else if (abort_i) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        if (cnt_q == 11'h000) begin
          run_q <= 1'b0;
          done_o <= 1'b1; // RL5
        end else if (tick_i) begin
          cnt_q <= cnt_q - 11'h001;
        end
      end
    end
  end

endmodule // swp_settle_timer

`default_nettype wire

// File: swp_i2c_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "swp_defs.vh"

module swp_i2c_slave #(
  parameter [6:0] SLV_ADDR = `SWP_I2C_ADDR
) (
  input wire core_clk_i, // system clock
  input wire rst_n_i, // sync reset, active low
  input wire scl_i, // serial clock pin
  input wire sda_i, // serial data pin, input side
  output wire sda_o, // serial data output level (always low)
  output reg sda_oe_o, // pulls data line low when high
  output reg wr_en_o, // one-cycle register write strobe
  output reg [7:0] wr_addr_o, // write address
  output reg [7:0] wr_data_o, // write data
  output reg [7:0] rd_addr_o, // address pointer for reads
  input wire [7:0] rd_data_i // read data at the pointer
);

  localparam [2:0] I_IDLE = 3'd0;
  localparam [2:0] I_ADDR = 3'd1;
  localparam [2:0] I_ACK = 3'd2;
  localparam [2:0] I_WR = 3'd3;
  localparam [2:0] I_RD = 3'd4;
  localparam [2:0] I_RACK = 3'd5;

  reg scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
  reg [2:0] st_q;
  reg [2:0] cnt_q;
  reg [7:0] sr_q;
  reg [7:0] tx_q;
  reg rw_q, ack_on_q, first_q, ptr_mode_q;
  wire [7:0] byte_in;
  wire rise, fall, start_c, stop_c;

  assign sda_o = 1'b0;
  assign byte_in = {sr_q[6:0], sda_s};
  assign rise = scl_s & ~scl_p;
  assign fall = ~scl_s & scl_p;
  assign start_c = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c = scl_s & scl_p & ~sda_p & sda_s;

  // pins cross in through two flops before anything looks at them
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      {scl_m, scl_s, scl_p} <= 3'b111;
      {sda_m, sda_s, sda_p} <= 3'b111;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
    end
  end

  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= I_IDLE;
      cnt_q <= 3'd0;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      ack_on_q <= 1'b0;
      first_q <= 1'b0;
      ptr_mode_q <= 1'b0;
      sda_oe_o <= 1'b0;
      wr_en_o <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
      rd_addr_o <= 8'h00;
    end else begin
      wr_en_o <= 1'b0;
      if (start_c) begin
        st_q <= I_ADDR;
        cnt_q <= 3'd0;
        sda_oe_o <= 1'b0;
        first_q <= 1'b1;
        ptr_mode_q <= 1'b0;
      end else if (stop_c) begin
        st_q <= I_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (st_q)
          I_ADDR: if (rise) begin
            sr_q <= byte_in;
            cnt_q <= cnt_q + 3'd1;
            if (cnt_q == 3'd7) begin
              ack_on_q <= 1'b0;
              rw_q <= sda_s;
              st_q <= (sr_q[6:0] == SLV_ADDR) ? I_ACK : I_IDLE;
            end
          end
          I_ACK: if (fall) begin
            if (!ack_on_q) begin
              sda_oe_o <= 1'b1;
              ack_on_q <= 1'b1;
            end else begin
              ack_on_q <= 1'b0;
              cnt_q <= 3'd0;
              if (rw_q) begin
                sda_oe_o <= ~rd_data_i[7];
                tx_q <= {rd_data_i[6:0], 1'b0};
                st_q <= I_RD;
              end else begin
                sda_oe_o <= 1'b0;
                st_q <= I_WR;
              end
            end
          end
          I_WR: if (rise) begin
            sr_q <= byte_in;
            cnt_q <= cnt_q + 3'd1;
            if (cnt_q == 3'd7) begin
              st_q <= I_ACK;
              if (first_q) begin
                first_q <= 1'b0;
                if (byte_in == `SWP_I2C_PTR_CMD)
                  ptr_mode_q <= 1'b1;
                else
                  rd_addr_o <= byte_in;
              end else if (ptr_mode_q) begin
                ptr_mode_q <= 1'b0;
                rd_addr_o <= byte_in;
              end else begin
                wr_en_o <= 1'b1;
                wr_addr_o <= rd_addr_o;
                wr_data_o <= byte_in;
              end
            end
          end
          I_RD: begin
            if (rise) begin
              cnt_q <= cnt_q + 3'd1;
              if (cnt_q == 3'd7) begin
                ack_on_q <= 1'b0;
                st_q <= I_RACK;
              end
            end else if (fall) begin
              sda_oe_o <= ~tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
          I_RACK: begin
            if (fall && !ack_on_q) begin
              sda_oe_o <= 1'b0;
              ack_on_q <= 1'b1;
            end else if (rise && ack_on_q) begin
              // master ack: next fall loads another byte from the same pointer
              st_q <= sda_s ? I_IDLE : I_ACK;
            end
          end
          default: st_q <= I_IDLE;
        endcase
      end
    end
  end

endmodule // swp_i2c_slave

`default_nettype wire

// File: swp_sweep_ctrl.v
// How it works
// RL1: point count is nine bits, upper bits ignored
// RL2: host keeps increment count at most 511
// RL3: point count untouched by reset or command
// RL4: settle register untouched by reset or command
// RL5: wait settle cycles before starting conversion
// RL6: settle base is nine bits across two bytes
// RL7: multiplier field scales by one, two, four
// RL8: settle delay reaches 2044 excitation cycles
// RL9: take 1024 samples, then store results
// RL10: one point converts in roughly 1 ms
// RL11: point-valid flag set when processing ends
// RL12: point-valid cleared by reset and measure commands
// RL13: sweep-done flag set after final point
// RL14: sweep-done cleared by reset, start, reset command
// RL15: temperature flag set on done, cleared on command
// RL16: status bits three to seven read zero
// RL17: sweep extent from count, start, increment
// RL18: top control nibble decodes the commands
// RL19: reset command aborts sweep, keeps sweep values
// RL20: increment steps point, then waits settle cycles
// RL21: count steps, flag done after last step
// RL22: reserved multiplier code acts as unscaled
`timescale 1ns/1ps
`default_nettype none
`include "swp_defs.vh"

module swp_sweep_ctrl #(
  parameter SAMPLES = `SWP_SAMPLES
) (
  input wire core_clk_i, // 200 MHz system clock
  input wire rst_n_i, // sync reset, active low
  input wire scl_i, // serial clock pin
  input wire sda_i, // serial data pin, input side
  output wire sda_o, // serial data output level
  output wire sda_oe_o, // serial data drive enable
  input wire exc_tick_i, // one pulse per excitation cycle
  input wire adc_valid_i, // one pulse per converter sample
  input wire dft_done_i, // transform finished pulse
  input wire [15:0] dft_real_i, // real result
  input wire [15:0] dft_imag_i, // imaginary result
  input wire temp_done_i, // temperature conversion finished
  input wire [13:0] temp_data_i, // temperature result
  output reg dds_init_o, // load start frequency pulse
  output reg dds_step_o, // add frequency increment pulse
  output reg adc_start_o, // begin sampling pulse
  output reg dft_start_o, // begin transform pulse
  output reg temp_start_o, // begin temperature reading pulse
  output reg [15:0] ctrl_word_o, // control word for analog front end
  output wire sweep_busy_o // a point measurement is running
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_SETTLE = 3'd1;
  localparam [2:0] S_SAMPLE = 3'd2;
  localparam [2:0] S_PROC = 3'd3;
  localparam [2:0] S_HOLD = 3'd4;
  localparam integer LAST_SAMPLE_I = SAMPLES - 1;
  localparam [10:0] LAST_SAMPLE = LAST_SAMPLE_I[10:0];

  wire wr_en;
  wire [7:0] wr_addr;
  wire [7:0] wr_data;
  wire [7:0] rd_addr;
  reg [7:0] rd_data;
  wire settle_done;

  // sweep setup registers have no reset on purpose
  reg [8:0] points_q;
  reg [8:0] settle_base_q;
  reg [1:0] settle_mult_q;
  reg [15:0] real_q;
  reg [15:0] imag_q;
  reg [13:0] temp_q;

  reg [2:0] st_q;
  reg [8:0] step_cnt_q;
  reg [10:0] samp_cnt_q;
  reg temp_ok_q;
  reg point_ok_q;
  reg sweep_done_q;

  wire cmd_hit;
  wire [3:0] cmd;
  wire c_init, c_start, c_inc, c_rep, c_temp, c_rst, c_meas;
  wire point_fin;
  wire last_point;

  swp_i2c_slave u_bus (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data)
  );

  // command decode acts on the write of the high control byte; the reset command is bit 4 of the low byte
  assign cmd_hit = wr_en && (wr_addr == `SWP_ADDR_CTRL_HI);
  assign cmd = wr_data[7:4]; // RL18
  assign c_init = cmd_hit && (cmd == `SWP_CMD_INIT);
  assign c_start = cmd_hit && (cmd == `SWP_CMD_START);
  assign c_inc = cmd_hit && (cmd == `SWP_CMD_INC);
  assign c_rep = cmd_hit && (cmd == `SWP_CMD_REPEAT);
  assign c_temp = cmd_hit && (cmd == `SWP_CMD_TEMP);
  assign c_rst = wr_en && (wr_addr == `SWP_ADDR_CTRL_LO) && wr_data[`SWP_CTRL_RST_BIT];
  assign c_meas = c_start | c_inc | c_rep;

  assign point_fin = (st_q == S_PROC) && dft_done_i;
  // frequencies live in the synthesizer; only the step count is kept here
  assign last_point = (step_cnt_q == points_q); // RL17
  assign sweep_busy_o = (st_q == S_SETTLE) || (st_q == S_SAMPLE) || (st_q == S_PROC);

  swp_settle_timer u_settle (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .load_i(c_meas),
    .abort_i(c_rst | c_init),
    .base_i(settle_base_q),
    .mult_i(settle_mult_q),
    .tick_i(exc_tick_i),
    .done_o(settle_done)
  );

  // control word and setup registers
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_word_o <= `SWP_CTRL_RESET_VAL;
    end else if (wr_en) begin
      if (wr_addr == `SWP_ADDR_CTRL_HI)
        ctrl_word_o[15:8] <= wr_data;
      if (wr_addr == `SWP_ADDR_CTRL_LO)
        ctrl_word_o[7:0] <= wr_data;
    end
  end

  always @(posedge core_clk_i) begin // RL3 RL4
    if (wr_en) begin
      case (wr_addr)
        `SWP_ADDR_PTS_HI: points_q[8] <= wr_data[0]; // RL1
        `SWP_ADDR_PTS_LO: points_q[7:0] <= wr_data; // RL1
        `SWP_ADDR_SETTLE_HI: begin
          settle_base_q[8] <= wr_data[0]; // RL6
          settle_mult_q <= wr_data[2:1]; // RL7
        end
        `SWP_ADDR_SETTLE_LO: settle_base_q[7:0] <= wr_data; // RL6
        default: ;
      endcase
    end
  end

  // results survive reset, like the setup registers
  always @(posedge core_clk_i) begin
    if (point_fin) begin
      real_q <= dft_real_i; // RL9
      imag_q <= dft_imag_i; // RL9
    end
    if (temp_done_i)
      temp_q <= temp_data_i;
  end

  // point sequencer
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_q <= S_IDLE;
      step_cnt_q <= 9'h000;
      samp_cnt_q <= 11'h000;
      dds_init_o <= 1'b0;
      dds_step_o <= 1'b0;
      adc_start_o <= 1'b0;
      dft_start_o <= 1'b0;
    end else begin
      dds_init_o <= c_init;
      dds_step_o <= c_inc; // RL20
      adc_start_o <= 1'b0;
      dft_start_o <= 1'b0;
      if (c_rst || c_init) begin
        st_q <= S_IDLE; // RL19
      end else if (c_meas) begin
        st_q <= S_SETTLE; // RL5
        if (c_start)
          step_cnt_q <= 9'h000;
        else if (c_inc)
          step_cnt_q <= step_cnt_q + 9'h001; // RL21
      end else begin
        case (st_q)
          S_SETTLE: if (settle_done) begin
            st_q <= S_SAMPLE;
            samp_cnt_q <= 11'h000;
            adc_start_o <= 1'b1; // RL5
          end
          S_SAMPLE: if (adc_valid_i) begin
            samp_cnt_q <= samp_cnt_q + 11'h001;
            // at 1 MSPS the sample run sets the roughly 1 ms point time
            if (samp_cnt_q == LAST_SAMPLE) begin
              st_q <= S_PROC; // RL10
              dft_start_o <= 1'b1; // RL9
            end
          end
          S_PROC: if (dft_done_i)
            st_q <= S_HOLD;
          S_HOLD: st_q <= S_HOLD;
          S_IDLE: st_q <= S_IDLE;
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

  // status flags: a set arriving with a clearing command wins
  always @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      temp_ok_q <= 1'b0;
      point_ok_q <= 1'b0; // RL12
      sweep_done_q <= 1'b0; // RL14
      temp_start_o <= 1'b0;
    end else begin
      temp_start_o <= c_temp;
      temp_ok_q <= temp_done_i | (temp_ok_q & ~c_temp); // RL15
      point_ok_q <= point_fin | (point_ok_q & ~(c_meas | c_rst)); // RL11 RL12
      sweep_done_q <= (point_fin & last_point) | (sweep_done_q & ~(c_start | c_rst)); // RL13 RL14
    end
  end

  // read mux; reserved status bits read as zero
  always @* begin
    case (rd_addr)
      `SWP_ADDR_CTRL_HI: rd_data = ctrl_word_o[15:8];
      `SWP_ADDR_CTRL_LO: rd_data = ctrl_word_o[7:0];
      `SWP_ADDR_PTS_HI: rd_data = {7'h00, points_q[8]};
      `SWP_ADDR_PTS_LO: rd_data = points_q[7:0];
      `SWP_ADDR_SETTLE_HI: rd_data = {5'h00, settle_mult_q, settle_base_q[8]};
      `SWP_ADDR_SETTLE_LO: rd_data = settle_base_q[7:0];
      `SWP_ADDR_STATUS: rd_data = {5'h00, sweep_done_q, point_ok_q, temp_ok_q}; // RL16
      `SWP_ADDR_TEMP_HI: rd_data = {2'b00, temp_q[13:8]};
      `SWP_ADDR_TEMP_LO: rd_data = temp_q[7:0];
      `SWP_ADDR_REAL_HI: rd_data = real_q[15:8];
      `SWP_ADDR_REAL_LO: rd_data = real_q[7:0];
      `SWP_ADDR_IMAG_HI: rd_data = imag_q[15:8];
      `SWP_ADDR_IMAG_LO: rd_data = imag_q[7:0];
      default: rd_data = 8'h00;
    endcase
  end

endmodule // swp_sweep_ctrl

`default_nettype wire

// File: swp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "swp_defs.vh"

module swp_host_model (
  output logic scl_o, // serial clock, idles high
  output logic sda_o, // data drive, high = released
  input wire logic sda_i // resolved data line
);
  localparam int QTR = 20;
  int nack_cnt = 0;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // data moves mid-low so it stays clear of both clock edges
  task automatic bit_io(input logic b, output logic q);
    #QTR sda_o = b;
    #QTR scl_o = 1'b1;
    #QTR q = sda_i;
    #QTR scl_o = 1'b0;
  endtask

  task automatic start();
    #QTR sda_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR sda_o = 1'b0;
    #QTR scl_o = 1'b0;
  endtask

  // clock is left high after stop: the line stands still between frames
  task automatic stop();
    #QTR sda_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR sda_o = 1'b1;
    #QTR;
  endtask

  task automatic tx(input logic [7:0] d);
    logic q;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q);
    bit_io(1'b1, q);
    if (q !== 1'b0) nack_cnt++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    tx({`SWP_I2C_ADDR, 1'b0});
    tx(a);
    tx(d);
    stop();
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic q;
    start();
    tx({`SWP_I2C_ADDR, 1'b0});
    tx(`SWP_I2C_PTR_CMD);
    tx(a);
    stop();
    start();
    tx({`SWP_I2C_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, q); // no acknowledge ends the read
    stop();
  endtask
endmodule // swp_host_model
`default_nettype wire

// File: swp_sweep_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module swp_sweep_ctrl_assertions #(
  parameter SAMPLES = 1024
) (
  input wire logic core_clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic adc_valid_i, // sample
  input wire logic dft_done_i, // result
  input wire logic dds_init_o, // init
  input wire logic dds_step_o, // step
  input wire logic adc_start_o, // conv
  input wire logic dft_start_o, // dft
  input wire logic temp_start_o, // temp
  input wire logic [15:0] ctrl_word_o, // ctrl
  input wire logic sweep_busy_o // busy
);
  logic [15:0] vcnt_q;

  always @(posedge core_clk_i) begin
    if (!rst_n_i || adc_start_o) vcnt_q <= 16'h0000;
    else if (adc_valid_i) vcnt_q <= vcnt_q + 16'h0001;
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_last_sample;
    adc_valid_i && vcnt_q == 16'(SAMPLES - 1);
  endsequence
  sequence s_proc_end;
    sweep_busy_o && dft_done_i;
  endsequence

  chk_dft_on_last: assert property (s_last_sample |=> dft_start_o)
    else $error("transform start missing after last sample");
  chk_dft_exact: assert property (dft_start_o |-> vcnt_q == 16'(SAMPLES))
    else $error("transform start at wrong sample count");
  chk_dft_busy: assert property (dft_start_o |-> sweep_busy_o)
    else $error("idle before transform result");
  chk_proc_idle: assert property (s_proc_end |=> !sweep_busy_o)
    else $error("still busy after result");
  chk_adc_once: assert property (adc_start_o |-> sweep_busy_o ##1 !adc_start_o[*4])
    else $error("conversion start outside a measurement");
  chk_step_settle: assert property (dds_step_o |-> sweep_busy_o ##1 !dds_step_o)
    else $error("step pulse without settling");
  chk_init_abort: assert property (dds_init_o |-> !sweep_busy_o && !adc_start_o)
    else $error("init left a measurement running");
  chk_temp_pulse: assert property (temp_start_o |=> !temp_start_o)
    else $error("temperature start longer than a cycle");
  chk_reset_state: assert property ($rose(rst_n_i) |-> ctrl_word_o == 16'ha000 && !sweep_busy_o)
    else $error("wrong state after reset");
endmodule // swp_sweep_ctrl_assertions

bind swp_sweep_ctrl swp_sweep_ctrl_assertions #(.SAMPLES(SAMPLES)) u_chk (
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .adc_valid_i(adc_valid_i),
  .dft_done_i(dft_done_i),
  .dds_init_o(dds_init_o),
  .dds_step_o(dds_step_o),
  .adc_start_o(adc_start_o),
  .dft_start_o(dft_start_o),
  .temp_start_o(temp_start_o),
  .ctrl_word_o(ctrl_word_o),
  .sweep_busy_o(sweep_busy_o)
);
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "swp_defs.vh"

module tb_top;
  localparam int NS = 16;
  logic core_clk_i = 1'b0, rst_n_i = 1'b0, exc_tick_i = 1'b0;
  logic adc_valid_i = 1'b0, dft_done_i = 1'b0, temp_done_i = 1'b0;
  logic [15:0] dft_real_i = 16'h0000, dft_imag_i = 16'h0000;
  logic [15:0] tcnt = 16'h0000, tk = 16'h0000;
  logic [13:0] temp_data_i = 14'h0000;
  logic [8:0] stp = 9'h000;
  logic [7:0] sh [256];
  wire scl, host_sda, sda_w, sda_o, sda_oe_o, dds_init_o, dds_step_o;
  wire adc_start_o, dft_start_o, temp_start_o, sweep_busy_o;
  wire [15:0] ctrl_word_o;
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 32'h0000_ca84;
  int n_adc = 0, n_step = 0, n_temp = 0, n_init = 0, cyc = 0;

  // pulled-up line: low while either side pulls
  assign sda_w = (sda_oe_o ? sda_o : 1'b1) & host_sda;

  swp_sweep_ctrl #(.SAMPLES(NS)) u_dut (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl),
    .sda_i(sda_w),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .exc_tick_i(exc_tick_i),
    .adc_valid_i(adc_valid_i),
    .dft_done_i(dft_done_i),
    .dft_real_i(dft_real_i),
    .dft_imag_i(dft_imag_i),
    .temp_done_i(temp_done_i),
    .temp_data_i(temp_data_i),
    .dds_init_o(dds_init_o),
    .dds_step_o(dds_step_o),
    .adc_start_o(adc_start_o),
    .dft_start_o(dft_start_o),
    .temp_start_o(temp_start_o),
    .ctrl_word_o(ctrl_word_o),
    .sweep_busy_o(sweep_busy_o)
  );
  swp_host_model u_host (
    .scl_o(scl),
    .sda_o(host_sda),
    .sda_i(sda_w)
  );

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    #1 exc_tick_i = (cyc % 4 == 0);
    cyc++;
  end

  // ticks are snapshot at conversion start, so late reads do not matter
  always @(posedge core_clk_i) begin
    if (sweep_busy_o === 1'b1 && exc_tick_i) tcnt++;
    if (adc_start_o === 1'b1) begin
      n_adc++;
      tk = tcnt;
    end
    if (dds_step_o === 1'b1) n_step++;
    if (dds_init_o === 1'b1) n_init++;
    if (temp_start_o === 1'b1) n_temp++;
  end

  task automatic step(int n = 1);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic cmp(logic [15:0] got, logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [15:0] exp_ticks();
    logic [15:0] b;
    b = {7'h00, sh[8'h8a][0], sh[8'h8b]};
    case (sh[8'h8a][2:1])
      2'b01: return b << 1;
      2'b11: return b << 2;
      default: return b;
    endcase
  endfunction

  task automatic wr(logic [7:0] a, logic [7:0] d);
    u_host.wr(a, d);
    if (a == 8'h88) d &= 8'h01;
    if (a == 8'h8a) d &= 8'h07;
    if (a == 8'h81 && d[4]) sh[8'h8f][2:1] = 2'b00;
    sh[a] = d;
  endtask

  task automatic rd_chk(logic [7:0] a);
    logic [7:0] d;
    u_host.rd(a, d);
    cmp({8'h00, d}, {8'h00, sh[a]});
  endtask

  task automatic cmd(logic [3:0] c);
    tcnt = 16'h0000;
    n_adc = 0;
    wr(8'h80, {c, 4'h0});
    cmp(ctrl_word_o, {sh[8'h80], sh[8'h81]});
    case (c)
      4'h2: {sh[8'h8f][2:1], stp} = 11'h000;
      4'h3: {sh[8'h8f][1], stp} = {1'b0, stp + 9'h001};
      4'h4: sh[8'h8f][1] = 1'b0;
      4'h9: sh[8'h8f][0] = 1'b0;
      default: ;
    endcase
  endtask

  task automatic meas();
    int i;
    i = 0;
    while (n_adc == 0) begin
      if (i++ == 10000) begin
        error_cnt++;
        stop_test();
      end
      step();
    end
    cmp(tk, exp_ticks());
    repeat (NS) begin
      adc_valid_i = 1'b1;
      step();
    end
    adc_valid_i = 1'b0;
    cmp(16'(dft_start_o), 16'h0001);
    {dft_real_i, dft_imag_i} = $random(seed);
    dft_done_i = 1'b1;
    step();
    dft_done_i = 1'b0;
    {sh[8'h94], sh[8'h95], sh[8'h96], sh[8'h97]} = {dft_real_i, dft_imag_i};
    sh[8'h8f][1] = 1'b1;
    if (stp == {sh[8'h88][0], sh[8'h89]}) sh[8'h8f][2] = 1'b1;
    rd_chk(8'h8f);
    for (int a = 8'h94; a < 8'h98; a++) rd_chk(8'(a));
  endtask

  initial begin
    foreach (sh[i]) sh[i] = 8'h00;
    sh[8'h80] = 8'ha0;
    step(4);
    rst_n_i = 1'b1;
    step(4);
    cmp(ctrl_word_o, 16'ha000);
    rd_chk(8'h8f);
    rd_chk(8'h8c);
    for (int a = 8'h88; a < 8'h8c; a++) begin
      wr(8'(a), 8'($random(seed)));
      rd_chk(8'(a));
    end
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h8a, {5'($random(seed)), 2'(m), 1'b0});
      // a zero count ends inside the two-cycle start latency, where ticks cannot be told apart
      wr(8'h8b, (8'($random(seed)) & 8'h0f) | 8'h01);
      wr(8'h88, 8'h00);
      wr(8'h89, 8'h01);
      cmd(4'h1);
      cmd(4'h2);
      meas();
      cmd(4'h3);
      rd_chk(8'h8f);
      meas();
      cmd(4'h4);
      rd_chk(8'h8f);
      meas();
      cmp(16'(n_step), 16'(m + 1));
      $display("test settle mode %0d done", m);
    end
    wr(8'h8a, 8'h07);
    wr(8'h8b, 8'hff);
    cmd(4'h4);
    wr(8'h81, 8'h10);
    cmp(16'(sweep_busy_o), 16'h0000);
    wr(8'h81, 8'h00);
    rd_chk(8'h8f);
    cmd(4'h1);
    cmd(4'h2);
    meas();
    $display("test abort and longest settle done");
    cmd(4'h9);
    rd_chk(8'h8f);
    temp_data_i = 14'($random(seed));
    temp_done_i = 1'b1;
    step();
    temp_done_i = 1'b0;
    {sh[8'h92], sh[8'h93]} = {2'b00, temp_data_i};
    sh[8'h8f][0] = 1'b1;
    rd_chk(8'h8f);
    rd_chk(8'h92);
    rd_chk(8'h93);
    cmd(4'h9);
    rd_chk(8'h8f);
    cmp(16'(n_temp), 16'h0002);
    $display("test temperature done");
    rst_n_i = 1'b0;
    step(4);
    rst_n_i = 1'b1;
    step(4);
    {sh[8'h8f], sh[8'h80], sh[8'h81]} = 24'h00_a000;
    cmp(ctrl_word_o, 16'ha000);
    for (int a = 8'h88; a < 8'h90; a++) rd_chk(8'(a));
    cmp(16'(u_host.nack_cnt), 16'h0000);
    cmp(16'(n_init), 16'h0005);
    $display("test second reset done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
